// ### hdl/urd_pkg.sv
package urd_pkg;

    // Register byte offsets and reset values.
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_STATUS    = 8'h04;
    localparam logic [7:0]  REG_STRAP     = 8'h08;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
    localparam int          CTRL_FWD_BIT  = 0;
    localparam int          ADDR_LSB      = 0;
    localparam int          ADDR_MSB      = 7;
    localparam int          HTRANS_ACTIVE = 1;

    // Status register fields.
    localparam int ST_STATE_LSB  = 0;
    localparam int ST_FOUND_LSB  = 4;
    localparam int ST_TERM_BIT   = 6;
    localparam int ST_IDLE_BIT   = 7;

    // Strap register: one byte per channel.
    localparam int STRAP_CH_W    = 8;
    localparam int STRAP_GAIN_LSB = 0;
    localparam int STRAP_AMP_BIT  = 2;
    localparam int STRAP_EMPH_LSB = 4;

    localparam int NUM_CH = 2;
    localparam int DATA_W = 32;
    localparam int BUF_DEPTH = 2;

    // Three-level strap codes, shared by the gain and emphasis selections.
    localparam logic [1:0] LVL_LOW   = 2'h0;
    localparam logic [1:0] LVL_FLOAT = 2'h1;
    localparam logic [1:0] LVL_HIGH  = 2'h2;
    // Gain: low 3 dB, floating 6 dB, high 9 dB.
    localparam logic [1:0] GAIN_3DB  = LVL_LOW;
    localparam logic [1:0] GAIN_6DB  = LVL_FLOAT;
    localparam logic [1:0] GAIN_9DB  = LVL_HIGH;
    // Emphasis: low 0 dB, floating -3.5 dB, high -6.2 dB.
    localparam logic [1:0] EMPH_0DB   = LVL_LOW;
    localparam logic [1:0] EMPH_3P5DB = LVL_FLOAT;
    localparam logic [1:0] EMPH_6P2DB = LVL_HIGH;
    // Amplitude: low 0.9 Vpp, high 1.1 Vpp.
    localparam logic AMP_0V9 = 1'b0;
    localparam logic AMP_1V1 = 1'b1;

    // Timing at the 40 MHz bus clock.
    localparam int CLK_MHZ        = 40;
    localparam int DET_PERIOD_US  = 12;
    localparam int DET_PERIOD_CYC = DET_PERIOD_US * CLK_MHZ;
    localparam int IDLE_TIME_NS   = 1000;
    localparam int IDLE_CYC       = (IDLE_TIME_NS * CLK_MHZ) / 1000;
    localparam int CNT_W          = 10;

    typedef enum logic [3:0] {
        ST_SHUT = 4'h1,
        ST_DISC = 4'h2,
        ST_U0   = 4'h4,
        ST_LOWP = 4'h8
    } urd_state_t;

endpackage : urd_pkg

// ### hdl/urd_stream_if.sv
`timescale 1ns/1ps
interface urd_stream_if;
    logic [urd_pkg::DATA_W-1:0] data;
    logic                       valid;
    logic                       ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : urd_stream_if

// ### hdl/urd_buffer.sv
`timescale 1ns/1ps
// Two-entry buffer; every output comes from a flip-flop.
module urd_buffer (
    input  wire logic  hclk,
    input  wire logic  hresetn,
    input  wire logic  acc_en_next,
    urd_stream_if.snk  in_s,
    urd_stream_if.src  out_s
);
    logic [urd_pkg::DATA_W-1:0] mem_reg [urd_pkg::BUF_DEPTH];
    logic [urd_pkg::DATA_W-1:0] mem_next [urd_pkg::BUF_DEPTH];
    logic [1:0]                 cnt_reg, cnt_next;
    logic                       rdp_reg, rdp_next;
    logic                       wrp_reg, wrp_next;
    logic                       inr_reg, inr_next;
    logic                       take, give;
    logic [urd_pkg::DATA_W-1:0] head_reg, head_next;
    logic                       vld_reg, vld_next;

    always_comb begin
        take     = in_s.valid && inr_reg;
        give     = (cnt_reg != 2'h0) && out_s.ready;
        mem_next = mem_reg;
        wrp_next = wrp_reg;
        rdp_next = rdp_reg;
        if (take) begin
            mem_next[wrp_reg] = in_s.data;
            wrp_next          = ~wrp_reg;
        end
        if (give) begin
            rdp_next = ~rdp_reg;
        end
        cnt_next = cnt_reg + {1'b0, take} - {1'b0, give};
        inr_next = (cnt_next != 2'(urd_pkg::BUF_DEPTH)) && acc_en_next;
        // The head word and its valid are registered copies of what the next cycle holds.
        head_next = mem_next[rdp_next];
        vld_next  = (cnt_next != 2'h0);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_reg <= '{default: '0};
            cnt_reg <= 2'h0;
            rdp_reg <= 1'b0;
            wrp_reg <= 1'b0;
            inr_reg <= 1'b0;
            head_reg <= '0;
            vld_reg <= 1'b0;
        end else begin
            mem_reg <= mem_next;
            cnt_reg <= cnt_next;
            rdp_reg <= rdp_next;
            wrp_reg <= wrp_next;
            inr_reg <= inr_next;
            head_reg <= head_next;
            vld_reg <= vld_next;
        end
    end

    assign in_s.ready  = inr_reg;
    assign out_s.valid = vld_reg;
    assign out_s.data  = head_reg;

endmodule : urd_buffer

// ### hdl/urd_link_ctrl.sv
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module urd_link_ctrl (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        detect_en,
    input  wire logic [1:0][1:0] rx_gain_strap,
    input  wire logic [1:0]  tx_amplitude_strap,
    input  wire logic [1:0][1:0] tx_emphasis_strap,
    input  wire logic [1:0]  lfps_present,
    input  wire logic [1:0]  ss_activity,
    input  wire logic        det_done,
    input  wire logic [1:0]  det_found,
    output logic             det_req,
    output logic             rx_term_en,
    output logic             tx_elec_idle,
    output logic [1:0][1:0]  rx_gain_sel,
    output logic [1:0]       tx_amp_sel,
    output logic [1:0][1:0]  tx_emph_sel,
    input  wire logic [31:0] rx_data,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    output logic [31:0]      tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Comparator pair {above high threshold, above low threshold} to a level code.
    function automatic logic [1:0] strap_level(input logic [1:0] cmp);
        if (cmp[1]) begin
            return urd_pkg::LVL_HIGH;
        end else if (cmp[0]) begin
            return urd_pkg::LVL_FLOAT;
        end
        return urd_pkg::LVL_LOW;
    endfunction : strap_level

    urd_pkg::urd_state_t      state_reg, state_next;
    logic [urd_pkg::CNT_W-1:0] det_cnt_reg, det_cnt_next;
    logic [urd_pkg::CNT_W-1:0] idle_cnt_reg, idle_cnt_next;
    logic                     det_req_reg, det_req_next;
    logic                     term_reg, term_next;
    logic                     eidle_reg, eidle_next;
    logic [1:0]               found_reg, found_next;
    logic                     load_reg, load_next;
    logic [1:0][1:0]          gain_reg, gain_next;
    logic [1:0]               amp_reg, amp_next;
    logic [1:0][1:0]          emph_cfg_reg, emph_cfg_next;
    logic [1:0][1:0]          emph_reg, emph_next;

    always_comb begin
        state_next    = state_reg;
        det_cnt_next  = det_cnt_reg;
        idle_cnt_next = idle_cnt_reg;
        det_req_next  = 1'b0;
        found_next    = found_reg;
        load_next     = 1'b0;
        if (det_done) begin
            found_next = det_found;
        end
        case (state_reg)
            urd_pkg::ST_SHUT: begin
                found_next = 2'h0;
                if (detect_en) begin
                    state_next   = urd_pkg::ST_DISC;
                    load_next    = 1'b1;
                    det_cnt_next = '0;
                end
            end
            urd_pkg::ST_DISC, urd_pkg::ST_LOWP: begin
                if (det_cnt_reg == '0) begin
                    det_req_next = 1'b1;
                    det_cnt_next = urd_pkg::CNT_W'(urd_pkg::DET_PERIOD_CYC - 1);
                end else begin
                    det_cnt_next = det_cnt_reg - 1'b1;
                end
                if (state_reg == urd_pkg::ST_DISC) begin
                    if (det_done && (det_found == 2'h3)) begin
                        state_next    = urd_pkg::ST_U0;
                        idle_cnt_next = '0;
                    end
                end else if (det_done && (det_found != 2'h3)) begin
                    state_next   = urd_pkg::ST_DISC;
                end else if ((ss_activity != 2'h0) || (lfps_present != 2'h0)) begin
                    state_next    = urd_pkg::ST_U0;
                    idle_cnt_next = '0;
                end
            end
            urd_pkg::ST_U0: begin
                if ((ss_activity != 2'h0) || (lfps_present != 2'h0)) begin
                    idle_cnt_next = '0;
                end else if (idle_cnt_reg == urd_pkg::CNT_W'(urd_pkg::IDLE_CYC - 1)) begin
                    state_next   = urd_pkg::ST_LOWP;
                    det_cnt_next = urd_pkg::CNT_W'(urd_pkg::DET_PERIOD_CYC - 1);
                end else begin
                    idle_cnt_next = idle_cnt_reg + 1'b1;
                end
            end
            default: begin
                state_next = urd_pkg::ST_SHUT;
            end
        endcase
        if (!detect_en) begin
            state_next = urd_pkg::ST_SHUT;
        end
        term_next  = (state_next == urd_pkg::ST_U0) || (state_next == urd_pkg::ST_LOWP);
        eidle_next = (state_next != urd_pkg::ST_U0) && (lfps_present == 2'h0);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg    <= urd_pkg::ST_SHUT;
            det_cnt_reg  <= '0;
            idle_cnt_reg <= '0;
            det_req_reg  <= 1'b0;
            term_reg     <= 1'b0;
            eidle_reg    <= 1'b1;
            found_reg    <= 2'h0;
            load_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            det_cnt_reg  <= det_cnt_next;
            idle_cnt_reg <= idle_cnt_next;
            det_req_reg  <= det_req_next;
            term_reg     <= term_next;
            eidle_reg    <= eidle_next;
            found_reg    <= found_next;
            load_reg     <= load_next;
        end
    end

    // Per-channel strap decode and the LFPS emphasis override.
    for (genvar ch = 0; ch < urd_pkg::NUM_CH; ch++) begin : g_ch
        always_comb begin
            gain_next[ch]     = gain_reg[ch];
            amp_next[ch]      = amp_reg[ch];
            emph_cfg_next[ch] = emph_cfg_reg[ch];
            if (load_next) begin
                gain_next[ch]     = strap_level(rx_gain_strap[ch]);
                amp_next[ch]      = tx_amplitude_strap[ch] ? urd_pkg::AMP_1V1
                                                           : urd_pkg::AMP_0V9;
                emph_cfg_next[ch] = strap_level(tx_emphasis_strap[ch]);
            end
            emph_next[ch] = lfps_present[ch] ? urd_pkg::EMPH_0DB
                                             : emph_cfg_next[ch];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gain_reg     <= '0;
            amp_reg      <= '0;
            emph_cfg_reg <= '0;
            emph_reg     <= '0;
        end else begin
            gain_reg     <= gain_next;
            amp_reg      <= amp_next;
            emph_cfg_reg <= emph_cfg_next;
            emph_reg     <= emph_next;
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY.
    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [7:0]  waddr_reg, waddr_next;
    logic        wpend_reg, wpend_next;
    logic        aphase;
    logic [31:0] ctrl_now;

    always_comb begin
        aphase     = hsel && hready && htrans[urd_pkg::HTRANS_ACTIVE];
        ctrl_next  = ctrl_reg;
        if (wpend_reg && (waddr_reg == urd_pkg::REG_CTRL)) begin
            ctrl_next = hwdata;
        end
        ctrl_now   = ctrl_next;
        wpend_next = aphase && hwrite;
        waddr_next = haddr[urd_pkg::ADDR_MSB:urd_pkg::ADDR_LSB];
        rdata_next = 32'h0000_0000;
        if (aphase && !hwrite) begin
            case (haddr[urd_pkg::ADDR_MSB:urd_pkg::ADDR_LSB])
                urd_pkg::REG_CTRL: begin
                    rdata_next[urd_pkg::CTRL_FWD_BIT] = ctrl_now[urd_pkg::CTRL_FWD_BIT];
                end
                urd_pkg::REG_STATUS: begin
                    rdata_next[urd_pkg::ST_STATE_LSB +: 4] = state_reg;
                    rdata_next[urd_pkg::ST_FOUND_LSB +: 2] = found_reg;
                    rdata_next[urd_pkg::ST_TERM_BIT]       = term_reg;
                    rdata_next[urd_pkg::ST_IDLE_BIT]       = eidle_reg;
                end
                urd_pkg::REG_STRAP: begin
                    for (int c = 0; c < urd_pkg::NUM_CH; c++) begin
                        rdata_next[c*urd_pkg::STRAP_CH_W + urd_pkg::STRAP_GAIN_LSB +: 2] =
                            gain_reg[c];
                        rdata_next[c*urd_pkg::STRAP_CH_W + urd_pkg::STRAP_AMP_BIT] =
                            amp_reg[c];
                        rdata_next[c*urd_pkg::STRAP_CH_W + urd_pkg::STRAP_EMPH_LSB +: 2] =
                            emph_cfg_reg[c];
                    end
                end
                default: begin
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg  <= urd_pkg::CTRL_RESET;
            rdata_reg <= 32'h0000_0000;
            waddr_reg <= 8'h00;
            wpend_reg <= 1'b0;
        end else begin
            ctrl_reg  <= ctrl_next;
            rdata_reg <= rdata_next;
            waddr_reg <= waddr_next;
            wpend_reg <= wpend_next;
        end
    end

    // Words are accepted only in U0 and only while forwarding is enabled by software; buffered words drain in any state.
    urd_stream_if in_s ();
    urd_stream_if out_s ();
    logic acc_en_next;

    assign acc_en_next = (state_next == urd_pkg::ST_U0) && ctrl_next[urd_pkg::CTRL_FWD_BIT];
    assign in_s.data   = rx_data;
    assign in_s.valid  = rx_valid;
    assign out_s.ready = tx_ready;

    urd_buffer urd_buffer_inst (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .acc_en_next (acc_en_next),
        .in_s        (in_s),
        .out_s       (out_s)
    );

    assign rx_ready     = in_s.ready;
    assign tx_data      = out_s.data;
    assign tx_valid     = out_s.valid;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign hrdata       = rdata_reg;
    assign det_req      = det_req_reg;
    assign rx_term_en   = term_reg;
    assign tx_elec_idle = eidle_reg;
    assign rx_gain_sel  = gain_reg;
    assign tx_amp_sel   = amp_reg;
    assign tx_emph_sel  = emph_reg;

    AST_DISC_DETECT: assert property (
        (state_reg == urd_pkg::ST_DISC) && detect_en && !det_done
        |-> ##[0:481] (det_req_reg || (state_reg != urd_pkg::ST_DISC)))
        else $error("no detection request in disconnect");
    AST_TERM_ON: assert property (
        (state_reg == urd_pkg::ST_DISC) && detect_en && det_done && (det_found == 2'h3)
        |=> term_reg && (state_reg == urd_pkg::ST_U0))
        else $error("termination not enabled after detection");
    AST_GAIN_DEC: assert property (
        load_reg |-> (gain_reg[0] == strap_level($past(rx_gain_strap[0]))))
        else $error("gain strap decoded wrongly");
    AST_AMP_DEC: assert property (
        load_reg |-> (amp_reg[1] == $past(tx_amplitude_strap[1])))
        else $error("amplitude strap decoded wrongly");
    AST_EMPH_LFPS: assert property (
        lfps_present[0] |=> (emph_reg[0] == urd_pkg::EMPH_0DB))
        else $error("emphasis not forced off during LFPS");
    AST_EMPH_CFG: assert property (
        !lfps_present[1] && !load_next |=> (emph_reg[1] == emph_cfg_reg[1]))
        else $error("emphasis does not follow strap");
    AST_U0_STAY: assert property (
        (state_reg == urd_pkg::ST_U0) && detect_en && (ss_activity != 2'h0)
        |=> (state_reg == urd_pkg::ST_U0))
        else $error("left U0 while traffic arrives");
    AST_U0_ENTRY: assert property (
        $rose(state_reg == urd_pkg::ST_U0) && ($past(state_reg) == urd_pkg::ST_DISC)
        |-> $past(det_done) && ($past(det_found) == 2'h3))
        else $error("U0 entered without both receivers");
    AST_SHUT: assert property (
        !detect_en |=> (state_reg == urd_pkg::ST_SHUT) && !term_reg)
        else $error("shutdown not entered");
    AST_IDLE: assert property (
        (state_reg == urd_pkg::ST_LOWP) && (lfps_present == 2'h0) && detect_en
        && (ss_activity == 2'h0) |=> tx_elec_idle)
        else $error("transmitter not idle in low power");
    AST_WAKE: assert property (
        (state_reg == urd_pkg::ST_SHUT) && detect_en |=> (state_reg == urd_pkg::ST_DISC)
            ##1 load_reg == 1'b0 ##0 det_req_reg)
        else $error("shutdown exit did not restart detection");

endmodule : urd_link_ctrl

// ### testbench/urd_far_end_model.sv
`timescale 1ns/1ps
// Far-end receiver detector: answers each request after a set delay.
module urd_far_end_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       det_req,
    input  wire logic [1:0] found_cfg,
    input  wire logic [3:0] resp_delay,
    output logic            det_done,
    output logic [1:0]      det_found
);
    logic [3:0] wait_cnt;
    logic       armed;
    logic [1:0] last_found;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed      <= 1'b0;
            wait_cnt   <= 4'h0;
            det_done   <= 1'b0;
            det_found  <= 2'h3;
            last_found <= 2'h0;
        end else begin
            det_done  <= 1'b0;
            // Outside an answer the found lines carry no stale result.
            det_found <= ~last_found;
            if (det_req) begin
                armed    <= 1'b1;
                wait_cnt <= resp_delay;
            end else if (armed && wait_cnt == 4'h0) begin
                armed      <= 1'b0;
                det_done   <= 1'b1;
                det_found  <= found_cfg;
                last_found <= found_cfg;
            end else if (armed) begin
                wait_cnt <= wait_cnt - 4'h1;
            end
        end
    end
endmodule : urd_far_end_model

// ### testbench/urd_link_ctrl_tb.sv
`timescale 1ns/1ps
module urd_link_ctrl_tb;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, detect_en;
    logic [31:0] haddr, hwdata, hrdata, rx_data, tx_data, rd;
    logic [1:0]  htrans, tx_amplitude_strap, lfps_present, ss_activity, det_found;
    logic [2:0]  hsize;
    logic [1:0][1:0] rx_gain_strap, tx_emphasis_strap, rx_gain_sel, tx_emph_sel;
    logic [1:0]  tx_amp_sel, found_cfg;
    logic        det_done, det_req, rx_term_en, tx_elec_idle;
    logic        rx_valid, rx_ready, tx_valid, tx_ready;
    int          failures, check_count, n;

    assign hready = hreadyout;

    urd_link_ctrl urd_link_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .detect_en(detect_en), .rx_gain_strap(rx_gain_strap),
        .tx_amplitude_strap(tx_amplitude_strap), .tx_emphasis_strap(tx_emphasis_strap),
        .lfps_present(lfps_present), .ss_activity(ss_activity), .det_done(det_done),
        .det_found(det_found), .det_req(det_req), .rx_term_en(rx_term_en),
        .tx_elec_idle(tx_elec_idle), .rx_gain_sel(rx_gain_sel), .tx_amp_sel(tx_amp_sel),
        .tx_emph_sel(tx_emph_sel), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

    urd_far_end_model urd_far_end_model_inst (.hclk(hclk), .hresetn(hresetn),
        .det_req(det_req), .found_cfg(found_cfg), .resp_delay(4'h3),
        .det_done(det_done), .det_found(det_found));

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask : check

    task complete_run();
        if (failures == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    // One single AHB transfer; read data is taken at the closing edge.
    task ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= addr;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask : ahb

    task state_is(input logic [3:0] st);
        ahb(1'b0, {24'h0, urd_pkg::REG_STATUS}, 32'h0);
        check({28'h0, rd[3:0]}, {28'h0, st}, "link state");
    endtask : state_is

    task wait_req(input int lim);
        n = 0;
        while (det_req !== 1'b1 && n < lim) begin
            @(negedge hclk);
            n++;
        end
        check(32'(n < lim), 32'h1, "detection request missing");
    endtask : wait_req

    task send(input logic [31:0] w);
        @(posedge hclk);
        rx_valid <= 1'b1;
        rx_data  <= w;
        do @(posedge hclk); while (rx_ready !== 1'b1);
        rx_valid <= 1'b0;
        rx_data  <= ~w;
    endtask : send

    task recv(input logic [31:0] exp);
        do @(posedge hclk); while (tx_valid !== 1'b1);
        check(tx_data, exp, "stream word");
    endtask : recv

    initial begin
        #(25 * 12000);
        failures++;
        complete_run();
    end

    initial begin
        failures = 0;
        check_count = 0;
        {hsel, hwrite, rx_valid, tx_ready} = 4'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        rx_data = 32'h0;
        lfps_present = 2'h0;
        ss_activity = 2'h0;
        found_cfg = 2'h1;
        detect_en = 1'b1;
        rx_gain_strap = {2'b01, 2'b00};
        tx_amplitude_strap = 2'b10;
        tx_emphasis_strap = {2'b01, 2'b11};
        hresetn = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 32'h0, 32'h0);
        check(rd, urd_pkg::CTRL_RESET, "ctrl reset");
        check({31'h0, hresp}, 32'h0, "okay response");
        ahb(1'b1, 32'h10, 32'hFFFF_FFFF);
        ahb(1'b0, 32'h10, 32'h0);
        check(rd, 32'h0, "unmapped read");
        ahb(1'b0, 32'h8, 32'h0);
        check(rd, 32'h0000_1520, "strap register");
        check({28'h0, rx_gain_sel}, 32'h4, "gain select");
        check({30'h0, tx_amp_sel}, 32'h2, "amplitude select");
        check({28'h0, tx_emph_sel}, 32'h6, "emphasis select");
        wait_req(1000);
        @(negedge hclk);
        n = 1;
        while (det_req !== 1'b1 && n < 1000) begin
            @(negedge hclk);
            n++;
        end
        check(n, urd_pkg::DET_PERIOD_CYC, "detection period");
        repeat (8) @(posedge hclk);
        state_is(urd_pkg::ST_DISC);
        @(posedge hclk) found_cfg <= 2'h3;
        ss_activity <= 2'h3;
        wait_req(1000);
        repeat (8) @(negedge hclk);
        check({31'h0, rx_term_en}, 32'h1, "receive termination");
        check({31'h0, tx_elec_idle}, 32'h0, "idle in U0");
        repeat (100) @(posedge hclk);
        state_is(urd_pkg::ST_U0);
        send(32'hA5A5_0001);
        send(32'hA5A5_0002);
        @(negedge hclk);
        check({31'h0, rx_ready}, 32'h0, "buffer full");
        @(posedge hclk) tx_ready <= 1'b1;
        recv(32'hA5A5_0001);
        recv(32'hA5A5_0002);
        @(negedge hclk);
        check({31'h0, tx_valid}, 32'h0, "buffer empty");
        ahb(1'b1, 32'h0, 32'h0);
        @(negedge hclk);
        check({31'h0, rx_ready}, 32'h0, "forwarding off");
        ahb(1'b1, 32'h0, 32'h1);
        @(posedge hclk) lfps_present <= 2'h1;
        repeat (2) @(negedge hclk);
        check({28'h0, tx_emph_sel}, 32'h4, "emphasis under lfps");
        @(posedge hclk) lfps_present <= 2'h0;
        repeat (2) @(negedge hclk);
        check({28'h0, tx_emph_sel}, 32'h6, "emphasis restored");
        @(posedge hclk) ss_activity <= 2'h0;
        repeat (urd_pkg::IDLE_CYC + 10) @(negedge hclk);
        check({31'h0, tx_elec_idle}, 32'h1, "electrical idle");
        state_is(urd_pkg::ST_LOWP);
        wait_req(1000);
        @(posedge hclk) found_cfg <= 2'h1;
        repeat (10) @(posedge hclk);
        state_is(urd_pkg::ST_DISC);
        check({31'h0, rx_term_en}, 32'h0, "termination off");
        @(posedge hclk) detect_en <= 1'b0;
        rx_gain_strap <= {2'b00, 2'b11};
        tx_amplitude_strap <= 2'b01;
        tx_emphasis_strap <= {2'b11, 2'b00};
        state_is(urd_pkg::ST_SHUT);
        n = 0;
        repeat (600) begin
            @(negedge hclk);
            n = n + int'(det_req === 1'b1);
        end
        check(n, 0, "requests in shutdown");
        @(posedge hclk) detect_en <= 1'b1;
        @(negedge hclk);
        wait_req(6);
        repeat (2) @(negedge hclk);
        check({28'h0, rx_gain_sel}, 32'h2, "gain resampled");
        check({30'h0, tx_amp_sel}, 32'h1, "amplitude resampled");
        check({28'h0, tx_emph_sel}, 32'h8, "emphasis resampled");
        complete_run();
    end
endmodule : urd_link_ctrl_tb
